// ### pma_engine.sv
// The register offsets and strobed register access were chosen for this implementation.
module pma_engine
    import pma_pkg::*;
#(
    parameter int OP_CYCLES = PMA_OP_CYCLES
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset_n,
    input  wire logic [PMA_SW_AW-1:0] i_sw_addr,
    input  wire logic [15:0]          i_sw_wdata,
    input  wire logic                 i_sw_wr,
    input  wire logic                 i_sw_rd,
    output logic      [15:0]          o_sw_rdata,
    output logic      [7:0]           o_dev_addr,
    output logic      [7:0]           o_dev_wdata,
    output logic                      o_dev_wr,
    output logic                      o_dev_rd,
    input  wire logic [7:0]           i_dev_rdata,
    output logic                      o_busy
);
    logic                    rst_n;
    pma_state_e              state_ff;
    pma_state_e              nxt_state;
    pma_op_e                 op_ff;
    logic [PMA_PHYREG_W-1:0] phyreg_ff;
    logic [PMA_PHYREG_W-1:0] sel_ff;
    logic [15:0]             wdata_ff;
    logic [15:0]             wsnap_ff;
    logic [15:0]             rdata_ff;
    logic [7:0]              rlo_ff;
    logic                    valid_ff;
    logic                    refused_ff;
    logic                    stop_req_ff;
    logic [15:0]             sw_rdata_ff;
    logic [7:0]              dev_addr_ff;
    logic [7:0]              dev_wdata_ff;
    logic                    dev_wr_ff;
    logic                    dev_rd_ff;
    logic [7:0]              nxt_dev_addr;
    logic [7:0]              nxt_dev_wdata;
    logic                    nxt_dev_wr;
    logic                    nxt_dev_rd;
    logic                    ctrl_wr;
    logic                    start_any;
    logic                    start_ok;
    logic                    stop_ok;
    logic                    timer_start;
    logic                    timer_done;
    logic                    poll_done;

    pma_reset_sync u_rst (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .o_rst_n    (rst_n)
    );

    pma_wait_timer #(
        .CYCLES (OP_CYCLES)
    ) u_timer (
        .i_core_clk (i_core_clk),
        .i_rst_n    (rst_n),
        .i_start    (timer_start),
        .o_done     (timer_done)
    );

    assign ctrl_wr   = i_sw_wr && (i_sw_addr == PMA_SW_CTRL);
    assign start_any = ctrl_wr && (i_sw_wdata[PMA_CTRL_READ]
                     || i_sw_wdata[PMA_CTRL_WRITE]
                     || i_sw_wdata[PMA_CTRL_SCAN]);
    // one operation at a time, never on a reserved or empty slot
    assign start_ok  = start_any && (state_ff == PMA_S_IDLE)
                     && pma_is_user_reg(phyreg_ff);
    assign stop_ok   = ctrl_wr && i_sw_wdata[PMA_CTRL_STOP]
                     && (op_ff == PMA_OP_SCAN)
                     && (state_ff != PMA_S_IDLE);

    // the device flags completion differently for the first scan read
    assign poll_done = (op_ff == PMA_OP_SCAN)
                     ? !i_dev_rdata[PMA_DST_NOT_VALID]
                     : !i_dev_rdata[PMA_DST_BUSY];

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PMA_S_IDLE:      if (start_ok) nxt_state = PMA_S_SEL_LO;
            PMA_S_SEL_LO:    nxt_state = PMA_S_SEL_HI;
            PMA_S_SEL_HI:    nxt_state = (op_ff == PMA_OP_WRITE)
                                       ? PMA_S_WR_LO : PMA_S_CMD_SET;
            PMA_S_CMD_SET:   nxt_state = PMA_S_WAIT;
            PMA_S_WR_LO:     nxt_state = PMA_S_WR_HI;
            PMA_S_WR_HI:     nxt_state = PMA_S_WAIT;
            PMA_S_WAIT:      if (timer_done) nxt_state = PMA_S_POLL;
            PMA_S_POLL:      nxt_state = PMA_S_POLL_CHK;
            PMA_S_POLL_CHK: begin
                if (!poll_done) begin
                    nxt_state = PMA_S_POLL;
                end else if (op_ff == PMA_OP_READ) begin
                    nxt_state = PMA_S_CMD_CLR;
                end else if (op_ff == PMA_OP_SCAN) begin
                    nxt_state = PMA_S_RD_LO;
                end else begin
                    nxt_state = PMA_S_IDLE;
                end
            end
            PMA_S_CMD_CLR:   nxt_state = PMA_S_RD_LO;
            PMA_S_RD_LO:     nxt_state = PMA_S_RD_LO_CAP;
            PMA_S_RD_LO_CAP: nxt_state = PMA_S_RD_HI;
            PMA_S_RD_HI:     nxt_state = PMA_S_RD_HI_CAP;
            PMA_S_RD_HI_CAP: begin
                if (op_ff == PMA_OP_READ) begin
                    nxt_state = PMA_S_IDLE;
                end else if (stop_req_ff || stop_ok) begin
                    nxt_state = PMA_S_STOP;
                end else begin
                    nxt_state = PMA_S_SCAN_WAIT;
                end
            end
            PMA_S_SCAN_WAIT: begin
                if (stop_req_ff || stop_ok) begin
                    nxt_state = PMA_S_STOP;
                end else if (timer_done) begin
                    nxt_state = PMA_S_RD_LO;
                end
            end
            PMA_S_STOP:      nxt_state = PMA_S_WAIT;
        endcase
    end

    assign timer_start = (nxt_state != state_ff)
                       && ((nxt_state == PMA_S_WAIT)
                       || (nxt_state == PMA_S_SCAN_WAIT));

    // device strobes are decoded from the state being entered, so they
    // leave flip-flops in step with that state
    always_comb begin
        nxt_dev_addr  = PMA_DEV_SEL_LO;
        nxt_dev_wdata = PMA_ZERO_BYTE;
        nxt_dev_wr    = 1'b0;
        nxt_dev_rd    = 1'b0;
        unique case (nxt_state)
            PMA_S_SEL_LO: begin
                nxt_dev_wr    = 1'b1;
                nxt_dev_addr  = PMA_DEV_SEL_LO;
                nxt_dev_wdata = {3'h0, phyreg_ff};
            end
            PMA_S_SEL_HI: begin
                nxt_dev_wr    = 1'b1;
                nxt_dev_addr  = PMA_DEV_SEL_HI;
                nxt_dev_wdata = PMA_SEL_HI_VAL;
            end
            PMA_S_CMD_SET: begin
                nxt_dev_wr    = 1'b1;
                nxt_dev_addr  = PMA_DEV_CMD_LO;
                nxt_dev_wdata = (op_ff == PMA_OP_SCAN) ? PMA_CMD_SCAN
                                                       : PMA_CMD_READ;
            end
            PMA_S_WR_LO: begin
                nxt_dev_wr    = 1'b1;
                nxt_dev_addr  = PMA_DEV_WR_LO;
                nxt_dev_wdata = wsnap_ff[7:0];
            end
            PMA_S_WR_HI: begin
                nxt_dev_wr    = 1'b1;
                nxt_dev_addr  = PMA_DEV_WR_HI;
                nxt_dev_wdata = wsnap_ff[15:8];
            end
            PMA_S_CMD_CLR, PMA_S_STOP: begin
                nxt_dev_wr    = 1'b1;
                nxt_dev_addr  = PMA_DEV_CMD_LO;
                nxt_dev_wdata = PMA_CMD_NONE;
            end
            PMA_S_POLL: begin
                nxt_dev_rd    = 1'b1;
                nxt_dev_addr  = PMA_DEV_STAT_LO;
            end
            PMA_S_RD_LO: begin
                nxt_dev_rd    = 1'b1;
                nxt_dev_addr  = PMA_DEV_RD_LO;
            end
            PMA_S_RD_HI: begin
                nxt_dev_rd    = 1'b1;
                nxt_dev_addr  = PMA_DEV_RD_HI;
            end
            default: ;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= PMA_S_IDLE;
            dev_addr_ff  <= PMA_DEV_SEL_LO;
            dev_wdata_ff <= PMA_ZERO_BYTE;
            dev_wr_ff    <= 1'b0;
            dev_rd_ff    <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            dev_addr_ff  <= nxt_dev_addr;
            dev_wdata_ff <= nxt_dev_wdata;
            dev_wr_ff    <= nxt_dev_wr;
            dev_rd_ff    <= nxt_dev_rd;
        end
    end

    // operation, target and write data are frozen at start so software
    // edits during the operation cannot tear it
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff    <= PMA_OP_READ;
            sel_ff   <= '0;
            wsnap_ff <= '0;
        end else if (start_ok) begin
            sel_ff   <= phyreg_ff;
            wsnap_ff <= wdata_ff;
            if (i_sw_wdata[PMA_CTRL_READ]) begin
                op_ff <= PMA_OP_READ;
            end else if (i_sw_wdata[PMA_CTRL_WRITE]) begin
                op_ff <= PMA_OP_WRITE;
            end else begin
                op_ff <= PMA_OP_SCAN;
            end
        end else if (nxt_state == PMA_S_STOP) begin
            op_ff <= PMA_OP_STOP;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phyreg_ff <= '0;
            wdata_ff  <= '0;
        end else if (i_sw_wr && (i_sw_addr == PMA_SW_PHYREG)) begin
            phyreg_ff <= i_sw_wdata[PMA_PHYREG_W-1:0];
        end else if (i_sw_wr && (i_sw_addr == PMA_SW_WDATA)) begin
            wdata_ff  <= i_sw_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_req_ff <= 1'b0;
        end else if (stop_ok) begin
            stop_req_ff <= 1'b1;
        end else if (state_ff == PMA_S_IDLE) begin
            stop_req_ff <= 1'b0;
        end
    end

    // both bytes land together, so after a single read software never sees a torn word
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rlo_ff   <= '0;
            rdata_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            if (state_ff == PMA_S_RD_LO_CAP) begin
                rlo_ff <= i_dev_rdata;
            end
            if (state_ff == PMA_S_RD_HI_CAP) begin
                rdata_ff <= {i_dev_rdata, rlo_ff};
                valid_ff <= 1'b1;
            end else if (start_ok && (i_sw_wdata[PMA_CTRL_READ]
                         || !i_sw_wdata[PMA_CTRL_WRITE])) begin
                valid_ff <= 1'b0;
            end
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            refused_ff <= 1'b0;
        end else if (start_any && !start_ok) begin
            refused_ff <= 1'b1;
        end else if (i_sw_wr && (i_sw_addr == PMA_SW_STATUS)
                     && i_sw_wdata[PMA_ST_REFUSED]) begin
            refused_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_rdata_ff <= '0;
        end else if (i_sw_rd) begin
            unique case (i_sw_addr)
                PMA_SW_PHYREG: sw_rdata_ff <= {11'h0, phyreg_ff};
                PMA_SW_WDATA:  sw_rdata_ff <= wdata_ff;
                PMA_SW_RDATA:  sw_rdata_ff <= rdata_ff;
                PMA_SW_STATUS: sw_rdata_ff <= {12'h0, refused_ff, valid_ff,
                    (op_ff == PMA_OP_SCAN) && (state_ff != PMA_S_IDLE),
                    state_ff != PMA_S_IDLE};
                default:       sw_rdata_ff <= '0;
            endcase
        end else begin
            sw_rdata_ff <= '0;
        end
    end

    assign o_sw_rdata  = sw_rdata_ff;
    assign o_dev_addr  = dev_addr_ff;
    assign o_dev_wdata = dev_wdata_ff;
    assign o_dev_wr    = dev_wr_ff;
    assign o_dev_rd    = dev_rd_ff;
    assign o_busy      = state_ff != PMA_S_IDLE;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    sel_high_val_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_SEL_HI
            |-> o_dev_wdata == PMA_SEL_HI_VAL)
        else $error("select high byte not written as 01");
    sel_before_op_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_SEL_LO
            |=> o_dev_wr && o_dev_addr == PMA_DEV_SEL_HI)
        else $error("select low byte not followed by high byte");
    wr_byte_order_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_WR_LO
            |=> o_dev_wr && o_dev_addr == PMA_DEV_WR_HI)
        else $error("write data high byte did not follow low byte");
    no_reserved_wr_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_WR_HI
            |-> pma_is_user_reg(sel_ff))
        else $error("write issued to reserved phy slot");
    no_wr_in_read_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_WR_LO |-> op_ff == PMA_OP_WRITE)
        else $error("write data touched during read or scan");
    wait_before_poll_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_CMD_LO
            && o_dev_wdata == PMA_CMD_READ |=> !o_dev_rd [*8])
        else $error("status polled before operation time");
    clear_then_fetch_a: assert property (
        o_dev_wr && o_dev_addr == PMA_DEV_CMD_LO
            && o_dev_wdata == PMA_CMD_NONE && op_ff == PMA_OP_READ
            |=> o_dev_rd && o_dev_addr == PMA_DEV_RD_LO)
        else $error("read data not fetched after enable cleared");
    refuse_busy_a: assert property (
        start_any && o_busy |=> refused_ff)
        else $error("start while busy was not refused");
    stop_waits_busy_a: assert property (
        state_ff == PMA_S_POLL_CHK && op_ff == PMA_OP_STOP
            && i_dev_rdata[PMA_DST_BUSY] |=> state_ff == PMA_S_POLL)
        else $error("scan stop ended before busy cleared");
endmodule

// ### pma_pkg.sv
// Function
// - host never writes reserved phy slots and ignores their read value
// - host loads register number and sets reserved bit 8 before any operation
// - while a read is busy host starts no scan, writes no write data
// - after busy clears host clears read enable, then fetches read data
// - phy writes replace all sixteen bits; read, modify, then write back
// - host loads write data low byte first, high byte second
// - while write is busy host starts no scan, write or read
// - during scan, low and high read bytes may come from different reads
// - while scanning host writes no write data and starts no single read
// - cancel scan by clearing scan enable, poll busy, then start anew
// - select register bits 4-0 hold register number, bits 12-8 hold 00001
package pma_pkg;

    // timing of one management operation
    localparam int PMA_OP_TIME_NS   = 25600;
    localparam int PMA_CLK_PERIOD_NS = 20;
    localparam int PMA_OP_CYCLES    =
        (PMA_OP_TIME_NS + PMA_CLK_PERIOD_NS - 1) / PMA_CLK_PERIOD_NS;

    // device register byte addresses on the device port
    localparam logic [7:0] PMA_DEV_SEL_LO   = 8'h00;
    localparam logic [7:0] PMA_DEV_SEL_HI   = 8'h01;
    localparam logic [7:0] PMA_DEV_CMD_LO   = 8'h02;
    localparam logic [7:0] PMA_DEV_WR_LO    = 8'h04;
    localparam logic [7:0] PMA_DEV_WR_HI    = 8'h05;
    localparam logic [7:0] PMA_DEV_RD_LO    = 8'h06;
    localparam logic [7:0] PMA_DEV_RD_HI    = 8'h07;
    localparam logic [7:0] PMA_DEV_STAT_LO  = 8'h08;

    // values written to the device
    localparam logic [7:0] PMA_SEL_HI_VAL   = 8'h01;
    localparam logic [7:0] PMA_CMD_NONE     = 8'h00;
    localparam logic [7:0] PMA_CMD_READ     = 8'h01;
    localparam logic [7:0] PMA_CMD_SCAN     = 8'h02;
    localparam logic [7:0] PMA_ZERO_BYTE    = 8'h00;

    // device status bits
    localparam int PMA_DST_BUSY   = 0;
    localparam int PMA_DST_SCAN   = 1;
    localparam int PMA_DST_NOT_VALID = 2;

    // software register map
    localparam int PMA_SW_AW = 3;
    localparam logic [PMA_SW_AW-1:0] PMA_SW_CTRL   = 3'h0;
    localparam logic [PMA_SW_AW-1:0] PMA_SW_PHYREG = 3'h1;
    localparam logic [PMA_SW_AW-1:0] PMA_SW_WDATA  = 3'h2;
    localparam logic [PMA_SW_AW-1:0] PMA_SW_RDATA  = 3'h3;
    localparam logic [PMA_SW_AW-1:0] PMA_SW_STATUS = 3'h4;

    localparam int PMA_CTRL_READ  = 0;
    localparam int PMA_CTRL_WRITE = 1;
    localparam int PMA_CTRL_SCAN  = 2;
    localparam int PMA_CTRL_STOP  = 3;

    localparam int PMA_ST_BUSY    = 0;
    localparam int PMA_ST_SCAN    = 1;
    localparam int PMA_ST_VALID   = 2;
    localparam int PMA_ST_REFUSED = 3;

    localparam int PMA_PHYREG_W = 5;
    // one bit per phy address that holds a usable register
    localparam logic [31:0] PMA_USER_REG_MASK = 32'h8802_0073;

    typedef enum logic [3:0] {
        PMA_S_IDLE     = 4'b0000,
        PMA_S_SEL_LO   = 4'b0001,
        PMA_S_SEL_HI   = 4'b0010,
        PMA_S_CMD_SET  = 4'b0011,
        PMA_S_WR_LO    = 4'b0100,
        PMA_S_WR_HI    = 4'b0101,
        PMA_S_WAIT     = 4'b0110,
        PMA_S_POLL     = 4'b0111,
        PMA_S_POLL_CHK = 4'b1000,
        PMA_S_CMD_CLR  = 4'b1001,
        PMA_S_RD_LO    = 4'b1010,
        PMA_S_RD_LO_CAP = 4'b1011,
        PMA_S_RD_HI    = 4'b1100,
        PMA_S_RD_HI_CAP = 4'b1101,
        PMA_S_SCAN_WAIT = 4'b1110,
        PMA_S_STOP     = 4'b1111
    } pma_state_e;

    typedef enum logic [1:0] {
        PMA_OP_READ  = 2'b00,
        PMA_OP_WRITE = 2'b01,
        PMA_OP_SCAN  = 2'b10,
        PMA_OP_STOP  = 2'b11
    } pma_op_e;

    function automatic logic pma_is_user_reg(input logic [4:0] num);
        return PMA_USER_REG_MASK[num];
    endfunction

endpackage

// ### pma_reset_sync.sv
module pma_reset_sync (
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    output logic      o_rst_n
);
    logic meta_ff;
    logic hold_ff;

    // asserts at once, releases two edges later to avoid a ragged release
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign o_rst_n = hold_ff;
endmodule

// ### pma_wait_timer.sv
module pma_wait_timer #(
    parameter int CYCLES = 1280
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_start,
    output logic      o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] count_ff;
    logic          done_ff;

    // done pulses exactly CYCLES edges after the start pulse
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff <= '0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= (count_ff == ONE);
            if (i_start) begin
                count_ff <= LOAD;
            end else if (count_ff != '0) begin
                count_ff <= count_ff - ONE;
            end
        end
    end

    assign o_done = done_ff;
endmodule

// ### pma_phy_model.sv
module pma_phy_model
    import pma_pkg::*;
#(
    parameter int OP = 10
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // usable slots 00 01 04 05 06 11 1b 1f
    localparam logic [31:0] USABLE = 32'h8802_0073;
    logic [15:0] phy_ff [32];
    logic [15:0] rd_ff, wr_val_ff;
    logic [7:0]  sel_lo_ff, sel_hi_ff, wr_lo_ff;
    logic        busy_ff, scan_ff, not_valid_ff, is_wr_ff;
    int          cnt_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 32; i++) phy_ff[i] <= 16'h0000;
            {busy_ff, scan_ff, not_valid_ff, is_wr_ff} <= 4'h0;
            {sel_lo_ff, sel_hi_ff, wr_lo_ff} <= 24'h0;
            rd_ff <= 16'h0000;
            wr_val_ff <= 16'h0000;
            cnt_ff <= 0;
        end else begin
            if (busy_ff && cnt_ff > 1) cnt_ff <= cnt_ff - 1;
            if (busy_ff && cnt_ff == 1) begin
                if (is_wr_ff && USABLE[sel_lo_ff[4:0]])
                    phy_ff[sel_lo_ff[4:0]] <= wr_val_ff;
                if (!is_wr_ff) begin
                    rd_ff <= USABLE[sel_lo_ff[4:0]] ?
                             phy_ff[sel_lo_ff[4:0]] : 16'hffff;
                    not_valid_ff <= 1'b0;
                end
                if (scan_ff && !is_wr_ff) cnt_ff <= OP;
                else busy_ff <= 1'b0;
            end
            if (i_wr) begin
                case (i_addr)
                    PMA_DEV_SEL_LO: sel_lo_ff <= i_wdata;
                    PMA_DEV_SEL_HI: sel_hi_ff <= i_wdata;
                    PMA_DEV_WR_LO:  wr_lo_ff <= i_wdata;
                    PMA_DEV_CMD_LO: begin
                        scan_ff <= i_wdata[1];
                        if (i_wdata[1:0] != 2'b00 && !busy_ff) begin
                            {busy_ff, not_valid_ff, is_wr_ff} <= 3'b110;
                            cnt_ff <= OP;
                        end
                    end
                    PMA_DEV_WR_HI: begin
                        {busy_ff, is_wr_ff} <= 2'b11;
                        wr_val_ff <= {i_wdata, wr_lo_ff};
                        cnt_ff <= OP;
                    end
                    default: ;
                endcase
            end
        end
    end
    // released data line inverts every cycle, so the last read value and its inverse alternate
    always_ff @(posedge i_core_clk) begin
        if (i_rd && i_addr == PMA_DEV_RD_LO) o_rdata <= rd_ff[7:0];
        else if (i_rd && i_addr == PMA_DEV_RD_HI) o_rdata <= rd_ff[15:8];
        else if (i_rd && i_addr == PMA_DEV_STAT_LO)
            o_rdata <= {5'h00, not_valid_ff, scan_ff, busy_ff};
        else o_rdata <= ~o_rdata;
    end
endmodule

// ### pma_engine_tb_top.sv
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module pma_engine_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pma_pkg::*;
    localparam int OPC = 10;
    logic        clk = 1'b0, rst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
    logic        rd1 = 1'b0;
    logic [2:0]  sw_addr = 3'h0;
    logic [15:0] sw_wdata = 16'h0000, sw_rdata, val;
    logic [7:0]  dev_addr, dev_wdata, dev_rdata;
    logic        dev_wr, dev_rd, busy;
    logic [15:0] exp_q[$], pv[32], exp_v;
    int          n_fail = 0, checked = 0, cyc = 0;
    logic [4:0]  slots[8] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06,
                              5'h11, 5'h1b, 5'h1f};
    initial forever #10 clk = ~clk;
    pma_engine #(.OP_CYCLES(OPC)) u_dut (.i_core_clk(clk), .i_reset_n(rst_n),
        .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr),
        .i_sw_rd(sw_rd), .o_sw_rdata(sw_rdata), .o_dev_addr(dev_addr),
        .o_dev_wdata(dev_wdata), .o_dev_wr(dev_wr), .o_dev_rd(dev_rd),
        .i_dev_rdata(dev_rdata), .o_busy(busy));
    pma_phy_model #(.OP(OPC)) u_model (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_addr(dev_addr), .i_wdata(dev_wdata), .i_wr(dev_wr),
        .i_rd(dev_rd), .o_rdata(dev_rdata));
    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd1) begin
            exp_v = exp_q.pop_front();
            `CHK("sw_rdata", exp_v, sw_rdata)
        end
        rd1 <= sw_rd;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [2:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
    endtask
    task automatic wait_idle();
        int i;
        repeat (3) @(posedge clk);
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
        `CHK("busy", 1'b0, busy)
    endtask
    initial begin
        void'($urandom(16107));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (slots[k]) begin
            val = 16'($urandom);
            pv[slots[k]] = val;
            sw_write(PMA_SW_PHYREG, {11'h000, slots[k]});
            sw_read(PMA_SW_PHYREG, {11'h000, slots[k]});
            sw_write(PMA_SW_WDATA, val);
            sw_write(PMA_SW_CTRL, 16'h0002);
            wait_idle();
            `CHK("sel_hi", 8'h01, u_model.sel_hi_ff)
            sw_write(PMA_SW_CTRL, 16'h0001);
            wait_idle();
            sw_read(PMA_SW_RDATA, val);
            sw_read(PMA_SW_STATUS, 16'h0004);
        end
        $display("test write_read done");
        sw_read(3'h5, 16'h0000);
        sw_write(PMA_SW_PHYREG, 16'h0002);
        sw_write(PMA_SW_CTRL, 16'h0001);
        sw_read(PMA_SW_STATUS, 16'h000c);
        sw_write(PMA_SW_STATUS, 16'h0008);
        sw_write(PMA_SW_PHYREG, 16'h0004);
        sw_write(PMA_SW_CTRL, 16'h0002);
        sw_write(PMA_SW_CTRL, 16'h0001);
        sw_read(PMA_SW_STATUS, 16'h000d);
        wait_idle();
        sw_write(PMA_SW_STATUS, 16'h0008);
        sw_read(PMA_SW_STATUS, 16'h0004);
        $display("test refusal done");
        sw_write(PMA_SW_PHYREG, 16'h001f);
        sw_write(PMA_SW_CTRL, 16'h0004);
        sw_read(PMA_SW_STATUS, 16'h0003);
        repeat (3 * OPC + 40) @(posedge clk);
        sw_read(PMA_SW_STATUS, 16'h0007);
        sw_read(PMA_SW_RDATA, pv[5'h1f]);
        sw_write(PMA_SW_CTRL, 16'h0008);
        wait_idle();
        sw_read(PMA_SW_RDATA, pv[5'h1f]);
        $display("test scan done");
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
